// ### hdl/regulator_request_consts.vh
`ifndef REGULATOR_REQUEST_CONSTS_VH
`define REGULATOR_REQUEST_CONSTS_VH

// ----------------------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------------------
`define RRQ_ADDR_CLUSTER_CPU_CTRL   12'h000
`define RRQ_ADDR_SYSTEM_CPU_CTRL    12'h004
`define RRQ_ADDR_CLUSTER_PIN_CFG    12'h008
`define RRQ_ADDR_SYSTEM_PIN_CFG     12'h00C
`define RRQ_ADDR_STOP_REQ_SET       12'h010
`define RRQ_ADDR_STOP_REQ_CLR       12'h014
`define RRQ_ADDR_ALWAYSON_CTRL      12'h018
`define RRQ_ADDR_STATUS             12'h01C

// ----------------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------------
`define RRQ_BIT_STANDBY_SEL_D1      0
`define RRQ_BIT_STANDBY_SEL_D2      1
`define RRQ_BIT_LOWPOWER_STOP_SEL         16
`define RRQ_BIT_LOW_VOLTAGE_SEL     17
`define RRQ_BIT_PIN_CFG             0
`define RRQ_BIT_ESLEEP_REQ          0
`define RRQ_BIT_STANDBY_SEL_D3      0

// ----------------------------------------------------------------------------
// reset values, system mode codes and cluster mode codes
// ----------------------------------------------------------------------------
`define RRQ_RESET_BIT               1'b0
`define RRQ_MODE_RUN                3'h0
`define RRQ_MODE_STOP               3'h1
`define RRQ_MODE_LOWPOWER_STOP            3'h2
`define RRQ_MODE_LOWPOWER_LOWVOLTAGE_STOP          3'h3
`define RRQ_MODE_STANDBY            3'h4
`define RRQ_CL_RUN                  2'h0
`define RRQ_CL_STOP1                2'h1
`define RRQ_CL_STOP23               2'h2
`define RRQ_CL_STANDBY              2'h3

`endif

// ### hdl/regulator_request_pin_logic.v
// What this block does
// - core request pin from system state and config
// - cpu request pin from cluster state and config
// - low-power pin from system state and system lowpower select
// - cluster control bit 16 selects cluster lowpower_stop
// - system control bit 16 drives low-power pin low in lowpower stops
// - cluster control bit 17 selects low-voltage stop
// - system control bit 17 selects low-voltage stop
// - cpu cfg 0: pin low only in standby
// - cpu cfg 1: pin high in run, stop1
// - core cfg 0: pin low only in standby
// - core cfg 1: pin high run, stop; low in lowpower stops
// - all pins low until power-on reset releases
// - battery backup mode tristates all three pins
// - core cfg 1 gives both pins 0 deep
// - enhanced sleep only when request bit set
// - lp stop1 needs a domain selecting stop
// - lowpower_stop needs both cpus stopped plus selects
// - always-on standby needs all conditions met
//
// Implementation choices: the placing of the registers and register access over APB.
`timescale 1ns/1ps
`default_nettype none
`include "regulator_request_consts.vh"

module regulator_request_pin_logic (
  // apb clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // apb slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  input  wire [3:0]  pstrb,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // power state inputs from the cpu subsystems (asynchronous)
  input  wire        cluster_cstop,
  input  wire        cluster_stop2_wanted,
  input  wire        system_cstop,
  input  wire        alwayson_cstop,
  input  wire        cluster_wfi,
  input  wire        battery_backup,
  // power state outputs
  output wire        enhanced_cpu_sleep,
  output wire        alwayson_standby,
  output wire [2:0]  system_mode,
  // regulator pins, oe low means driven
  output wire        core_supply_request_o,
  output wire        core_supply_request_oe_n,
  output wire        cluster_supply_request_o,
  output wire        cluster_supply_request_oe_n,
  output wire        core_regulator_lowpower_n_o,
  output wire        core_regulator_lowpower_n_oe_n
);

  // --------------------------------------------------------------------------
  // configuration registers
  // --------------------------------------------------------------------------
  // register map, one aligned word each:
  //   0x00 cluster cpu control: standby selects in bits 1:0,
  //        lowpower select bit 16, low-voltage select bit 17
  //   0x04 system cpu control: system standby select bit 1,
  //        lowpower select bit 16, low-voltage select bit 17
  //   0x08 cluster request pin mapping, bit 0
  //   0x0c core request pin mapping, bit 0
  //   0x10 write 1 to bit 0 raises the enhanced sleep request
  //   0x14 write 1 to bit 0 drops it again
  //   0x18 always-on standby select, bit 0
  //   0x1c read-only status of pins, mode and sleep flags
  // only byte lanes 0 and 2 hold bits, so other strobes are ignored
  reg        cluster_lowpower_stop_select_q;
  reg        cluster_low_voltage_select_q;
  reg        cluster_deepsleep_standby_sel_q;
  reg        system_deepsleep_standby_sel_c1_q;
  reg        system_lowpower_stop_select_q;
  reg        system_low_voltage_select_q;
  reg        system_deepsleep_standby_sel_q;
  reg        cluster_request_pin_cfg_q;
  reg        core_request_pin_cfg_q;
  reg        enhanced_sleep_request_q;
  reg        alwayson_deepsleep_standby_sel_q;
  reg [31:0] prdata_q;
  reg        pslverr_q;

  wire       wr_en = psel & penable & pwrite;
  wire       addr_hit;

  assign addr_hit = (paddr == `RRQ_ADDR_CLUSTER_CPU_CTRL) |
                    (paddr == `RRQ_ADDR_SYSTEM_CPU_CTRL) |
                    (paddr == `RRQ_ADDR_CLUSTER_PIN_CFG) |
                    (paddr == `RRQ_ADDR_SYSTEM_PIN_CFG) |
                    (paddr == `RRQ_ADDR_STOP_REQ_SET) |
                    (paddr == `RRQ_ADDR_STOP_REQ_CLR) |
                    (paddr == `RRQ_ADDR_ALWAYSON_CTRL) |
                    (paddr == `RRQ_ADDR_STATUS);

  // zero wait states: the access phase always completes at once
  assign pready  = 1'b1;
  assign prdata  = prdata_q;
  assign pslverr = pslverr_q;

  // register writes; selects and pin mappings start at plain stop
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cluster_lowpower_stop_select_q          <= `RRQ_RESET_BIT;
      cluster_low_voltage_select_q      <= `RRQ_RESET_BIT;
      cluster_deepsleep_standby_sel_q   <= `RRQ_RESET_BIT;
      system_deepsleep_standby_sel_c1_q <= `RRQ_RESET_BIT;
      system_lowpower_stop_select_q           <= `RRQ_RESET_BIT;
      system_low_voltage_select_q       <= `RRQ_RESET_BIT;
      system_deepsleep_standby_sel_q    <= `RRQ_RESET_BIT;
      cluster_request_pin_cfg_q         <= `RRQ_RESET_BIT;
      core_request_pin_cfg_q            <= `RRQ_RESET_BIT;
      enhanced_sleep_request_q          <= `RRQ_RESET_BIT;
      alwayson_deepsleep_standby_sel_q  <= `RRQ_RESET_BIT;
    end else if (wr_en) begin
      if (paddr == `RRQ_ADDR_CLUSTER_CPU_CTRL) begin
        if (pstrb[0]) begin
          cluster_deepsleep_standby_sel_q   <= pwdata[`RRQ_BIT_STANDBY_SEL_D1];
          system_deepsleep_standby_sel_c1_q <= pwdata[`RRQ_BIT_STANDBY_SEL_D2];
        end
        if (pstrb[2]) begin
          cluster_lowpower_stop_select_q     <= pwdata[`RRQ_BIT_LOWPOWER_STOP_SEL];
          cluster_low_voltage_select_q <= pwdata[`RRQ_BIT_LOW_VOLTAGE_SEL];
        end
      end
      if (paddr == `RRQ_ADDR_SYSTEM_CPU_CTRL) begin
        if (pstrb[0]) begin
          system_deepsleep_standby_sel_q <= pwdata[`RRQ_BIT_STANDBY_SEL_D2];
        end
        if (pstrb[2]) begin
          system_lowpower_stop_select_q     <= pwdata[`RRQ_BIT_LOWPOWER_STOP_SEL];
          system_low_voltage_select_q <= pwdata[`RRQ_BIT_LOW_VOLTAGE_SEL];
        end
      end
      if (paddr == `RRQ_ADDR_CLUSTER_PIN_CFG && pstrb[0]) begin
        cluster_request_pin_cfg_q <= pwdata[`RRQ_BIT_PIN_CFG];
      end
      if (paddr == `RRQ_ADDR_SYSTEM_PIN_CFG && pstrb[0]) begin
        core_request_pin_cfg_q <= pwdata[`RRQ_BIT_PIN_CFG];
      end
      // set register only sets; a separate clear register drops the request
      if (paddr == `RRQ_ADDR_STOP_REQ_SET && pstrb[0] && pwdata[`RRQ_BIT_ESLEEP_REQ]) begin
        enhanced_sleep_request_q <= 1'b1;
      end
      if (paddr == `RRQ_ADDR_STOP_REQ_CLR && pstrb[0] && pwdata[`RRQ_BIT_ESLEEP_REQ]) begin
        enhanced_sleep_request_q <= 1'b0;
      end
      if (paddr == `RRQ_ADDR_ALWAYSON_CTRL && pstrb[0]) begin
        alwayson_deepsleep_standby_sel_q <= pwdata[`RRQ_BIT_STANDBY_SEL_D3];
      end
    end
  end

  // --------------------------------------------------------------------------
  // input synchronisers
  // --------------------------------------------------------------------------
  // the stop flags come from other power domains and the battery
  // flag from the supply monitor, so none of them shares this clock;
  // a change reaches the pins three edges later, which software
  // must allow for before it reads the status word
  reg [5:0] sync1_q;
  reg [5:0] sync2_q;

  // first stage read only by the second stage
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      sync1_q <= 6'h00;
      sync2_q <= 6'h00;
    end else begin
      sync1_q <= {battery_backup, cluster_wfi, alwayson_cstop,
                  system_cstop, cluster_stop2_wanted, cluster_cstop};
      sync2_q <= sync1_q;
    end
  end

  wire cl_cstop  = sync2_q[0];
  wire cl_stop2  = sync2_q[1];
  wire sys_cstop = sync2_q[2];
  wire ao_cstop  = sync2_q[3];
  wire cl_wfi    = sync2_q[4];
  wire vbat_mode = sync2_q[5];

  // --------------------------------------------------------------------------
  // mode decode
  // --------------------------------------------------------------------------
  // system mode, from the synchronised stop flags and the selects:
  //   run       one of the cpus still running
  //   stop      both stopped, no deep flavour selected
  //   lowpower  both lowpower selects set, one domain keeps stop
  //   low-volt  as lowpower, with both low-voltage selects set too
  //   standby   cluster and both system standby selects set
  // cluster mode: run, stop1, stop2/3 (stop2 wanted or lowpower
  // select) and standby; it only steers the cluster request pin
  reg [2:0] sys_mode_d;
  reg [1:0] cl_mode_d;
  wire      cl_standby_ok  = cluster_deepsleep_standby_sel_q;
  wire      sys_standby_ok = system_deepsleep_standby_sel_q &
                             system_deepsleep_standby_sel_c1_q;
  wire      any_stop_sel   = ~cluster_deepsleep_standby_sel_q |
                             ~system_deepsleep_standby_sel_q;

  // deep modes need both cpus stopped; standby wins over stop flavours
  always @* begin
    sys_mode_d = `RRQ_MODE_RUN;
    if (cl_cstop && sys_cstop) begin
      if (sys_standby_ok && cl_standby_ok) begin
        sys_mode_d = `RRQ_MODE_STANDBY;
      end else if (any_stop_sel && system_lowpower_stop_select_q &&
                   cluster_lowpower_stop_select_q) begin
        if (system_low_voltage_select_q && cluster_low_voltage_select_q) begin
          sys_mode_d = `RRQ_MODE_LOWPOWER_LOWVOLTAGE_STOP;
        end else begin
          sys_mode_d = `RRQ_MODE_LOWPOWER_STOP;
        end
      end else begin
        sys_mode_d = `RRQ_MODE_STOP;
      end
    end
    cl_mode_d = `RRQ_CL_RUN;
    if (cl_cstop) begin
      if (cl_standby_ok) begin
        cl_mode_d = `RRQ_CL_STANDBY;
      end else if (cl_stop2 || cluster_lowpower_stop_select_q) begin
        cl_mode_d = `RRQ_CL_STOP23;
      end else begin
        cl_mode_d = `RRQ_CL_STOP1;
      end
    end
  end

  // --------------------------------------------------------------------------
  // pin values
  // --------------------------------------------------------------------------
  // pin table, mapping bit 0 / mapping bit 1:
  //   core request   low only in standby / low in every deep mode
  //   cluster req    low only in standby / also low in stop2/3
  //   lowpower_n     low in deep stop when system select is set,
  //                  and low in standby, whatever the mapping
  // with both mappings at 1 the core pins read 00 in every deep
  // mode, which is what an external power chip expects to see;
  // released pins in battery backup are handled by the enables
  reg core_req_d;
  reg cpu_req_d;
  reg lp_n_d;

  always @* begin
    case (sys_mode_d)
      `RRQ_MODE_RUN, `RRQ_MODE_STOP: begin
        core_req_d = 1'b1;
        lp_n_d     = 1'b1;
      end
      `RRQ_MODE_LOWPOWER_STOP, `RRQ_MODE_LOWPOWER_LOWVOLTAGE_STOP: begin
        core_req_d = ~core_request_pin_cfg_q;
        lp_n_d     = ~system_lowpower_stop_select_q;
      end
      `RRQ_MODE_STANDBY: begin
        core_req_d = 1'b0;
        lp_n_d     = 1'b0;
      end
      default: begin
        core_req_d = 1'b1;
        lp_n_d     = 1'b1;
      end
    endcase
    case (cl_mode_d)
      `RRQ_CL_RUN, `RRQ_CL_STOP1: cpu_req_d = 1'b1;
      `RRQ_CL_STOP23: cpu_req_d = ~cluster_request_pin_cfg_q;
      `RRQ_CL_STANDBY: cpu_req_d = 1'b0;
      default: cpu_req_d = 1'b1;
    endcase
  end

  // --------------------------------------------------------------------------
  // registered outputs
  // --------------------------------------------------------------------------
  // every pin leaves a flip-flop: the decode above is wide and
  // would glitch on the pins while selects and stop flags settle;
  // the trade is one more cycle of latency after each input change
  // during reset the pins are driven low, not released
  reg       core_req_q;
  reg       cpu_req_q;
  reg       lp_n_q;
  reg       pins_oe_n_q;
  reg [2:0] sys_mode_q;
  reg       esleep_q;
  reg       ao_standby_q;

  // reset holds all pins driven low, as the startup table demands
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      core_req_q   <= 1'b0;
      cpu_req_q    <= 1'b0;
      lp_n_q       <= 1'b0;
      pins_oe_n_q  <= 1'b0;
      sys_mode_q   <= `RRQ_MODE_RUN;
      esleep_q     <= 1'b0;
      ao_standby_q <= 1'b0;
    end else begin
      core_req_q   <= core_req_d;
      cpu_req_q    <= cpu_req_d;
      lp_n_q       <= lp_n_d;
      pins_oe_n_q  <= vbat_mode;
      sys_mode_q   <= sys_mode_d;
      esleep_q     <= enhanced_sleep_request_q & cl_wfi & ~cl_cstop;
      ao_standby_q <= (sys_mode_d == `RRQ_MODE_STANDBY) & ao_cstop &
                      alwayson_deepsleep_standby_sel_q;
    end
  end

  assign core_supply_request_o          = core_req_q;
  assign cluster_supply_request_o       = cpu_req_q;
  assign core_regulator_lowpower_n_o    = lp_n_q;
  assign core_supply_request_oe_n       = pins_oe_n_q;
  assign cluster_supply_request_oe_n    = pins_oe_n_q;
  assign core_regulator_lowpower_n_oe_n = pins_oe_n_q;
  assign enhanced_cpu_sleep             = esleep_q;
  assign alwayson_standby               = ao_standby_q;
  assign system_mode                    = sys_mode_q;

  // --------------------------------------------------------------------------
  // read data
  // --------------------------------------------------------------------------
  // reads are decoded in the setup cycle and registered, so prdata
  // stands through the whole access phase; status writes are ignored
  reg [31:0] rdata_d;

  always @* begin
    rdata_d = 32'h0000_0000;
    case (paddr)
      `RRQ_ADDR_CLUSTER_CPU_CTRL: begin
        rdata_d[`RRQ_BIT_STANDBY_SEL_D1]  = cluster_deepsleep_standby_sel_q;
        rdata_d[`RRQ_BIT_STANDBY_SEL_D2]  = system_deepsleep_standby_sel_c1_q;
        rdata_d[`RRQ_BIT_LOWPOWER_STOP_SEL]     = cluster_lowpower_stop_select_q;
        rdata_d[`RRQ_BIT_LOW_VOLTAGE_SEL] = cluster_low_voltage_select_q;
      end
      `RRQ_ADDR_SYSTEM_CPU_CTRL: begin
        rdata_d[`RRQ_BIT_STANDBY_SEL_D2]  = system_deepsleep_standby_sel_q;
        rdata_d[`RRQ_BIT_LOWPOWER_STOP_SEL]     = system_lowpower_stop_select_q;
        rdata_d[`RRQ_BIT_LOW_VOLTAGE_SEL] = system_low_voltage_select_q;
      end
      `RRQ_ADDR_CLUSTER_PIN_CFG: rdata_d[`RRQ_BIT_PIN_CFG] = cluster_request_pin_cfg_q;
      `RRQ_ADDR_SYSTEM_PIN_CFG:  rdata_d[`RRQ_BIT_PIN_CFG] = core_request_pin_cfg_q;
      `RRQ_ADDR_STOP_REQ_SET:    rdata_d[`RRQ_BIT_ESLEEP_REQ] = enhanced_sleep_request_q;
      `RRQ_ADDR_STOP_REQ_CLR:    rdata_d[`RRQ_BIT_ESLEEP_REQ] = enhanced_sleep_request_q;
      `RRQ_ADDR_ALWAYSON_CTRL:   rdata_d[`RRQ_BIT_STANDBY_SEL_D3] = alwayson_deepsleep_standby_sel_q;
      // status: pins, mode, sleep flags
      `RRQ_ADDR_STATUS: rdata_d[8:0] = {esleep_q, ao_standby_q, sys_mode_q,
                                        pins_oe_n_q, lp_n_q, cpu_req_q, core_req_q};
      default: rdata_d = 32'h0000_0000;
    endcase
  end

  // read data and error are registered at the setup phase, valid in access
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q  <= 32'h0000_0000;
      pslverr_q <= 1'b0;
    end else if (psel && !penable) begin
      prdata_q  <= pwrite ? 32'h0000_0000 : rdata_d;
      pslverr_q <= ~addr_hit;
    end else if (!psel) begin
      pslverr_q <= 1'b0;
    end
  end

endmodule

`default_nettype wire

// ### verification/regulator_model.sv
`timescale 1ns/1ps
`default_nettype none
module regulator_model (
  // pin values and output enables from the block
  input  wire logic       core_o,
  input  wire logic       core_oe_n,
  input  wire logic       cpu_o,
  input  wire logic       cpu_oe_n,
  input  wire logic       lp_o,
  input  wire logic       lp_oe_n,
  // levels seen at the regulator inputs: core, cluster, low-power
  output wire logic [2:0] lvl
);
  // weak pull-downs on the regulator side, so a released pin reads 0, not a stale level
  assign lvl = {core_oe_n ? 1'b0 : core_o, cpu_oe_n ? 1'b0 : cpu_o,
                lp_oe_n ? 1'b0 : lp_o};
endmodule
`default_nettype wire

// ### verification/regulator_request_chk.sv
`timescale 1ns/1ps
`default_nettype none
`include "regulator_request_consts.vh"
module regulator_request_chk (
  // clock, reset and apb
  input wire logic        pclk,
  input wire logic        presetn,
  input wire logic        psel,
  input wire logic        penable,
  input wire logic        pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0]  pstrb,
  input wire logic [31:0] prdata,
  input wire logic        pready,
  // power state
  input wire logic        cluster_cstop,
  input wire logic        battery_backup,
  input wire logic        alwayson_standby,
  input wire logic [2:0]  system_mode,
  // regulator pins
  input wire logic        core_supply_request_o,
  input wire logic        core_supply_request_oe_n,
  input wire logic        cluster_supply_request_o,
  input wire logic        cluster_supply_request_oe_n,
  input wire logic        core_regulator_lowpower_n_o,
  input wire logic        core_regulator_lowpower_n_oe_n
);
  wire       core = core_supply_request_o;
  wire       cpu  = cluster_supply_request_o;
  wire       lp_n = core_regulator_lowpower_n_o;
  logic      core_cfg_q;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // shadow of the core pin config, since deep-mode pin values hang on it
  always @(posedge pclk or negedge presetn) begin
    if (!presetn)
      core_cfg_q <= 1'b0;
    else if (psel && penable && pwrite && pready && pstrb[0]
             && paddr == `RRQ_ADDR_SYSTEM_PIN_CFG)
      core_cfg_q <= pwdata[0];
  end
  // a mode must hold three cycles before its pins are judged (output flop lag)
  sequence mode_held(logic [2:0] m);
    (system_mode == m)[*3];
  endsequence
  sequence deep_held;
    ((system_mode == `RRQ_MODE_LOWPOWER_STOP || system_mode == `RRQ_MODE_LOWPOWER_LOWVOLTAGE_STOP)
      && $stable(core_cfg_q))[*3];
  endsequence
  a_run_pins_on: assert property (mode_held(`RRQ_MODE_RUN) |-> core && lp_n)
    else $error("run mode pins not high");
  a_stop_pins_on: assert property (mode_held(`RRQ_MODE_STOP) |-> core && lp_n)
    else $error("stop mode pins not high");
  a_deep_pins: assert property (deep_held |-> core == !core_cfg_q && !lp_n)
    else $error("deep stop pins wrong");
  a_standby_off: assert property (mode_held(`RRQ_MODE_STANDBY) |-> !core && !cpu && !lp_n)
    else $error("standby pins not low");
  a_cpu_run_on: assert property ((!cluster_cstop)[*4] |=> cpu)
    else $error("cluster request low while cluster runs");
  a_battery_hiz: assert property (battery_backup[*4] |=> {core_supply_request_oe_n,
    cluster_supply_request_oe_n, core_regulator_lowpower_n_oe_n} == 3'h7)
    else $error("pins still driven in battery mode");
  a_aon_cause: assert property ($rose(alwayson_standby) |->
    system_mode == `RRQ_MODE_STANDBY || $past(system_mode) == `RRQ_MODE_STANDBY)
    else $error("always-on standby without system standby");
  a_status_mirror: assert property (psel && !penable && !pwrite
    && paddr == `RRQ_ADDR_STATUS |=> prdata[2:0] == {$past(lp_n), $past(cpu), $past(core)})
    else $error("status read differs from pins");
endmodule
bind regulator_request_pin_logic regulator_request_chk u_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .pready, .cluster_cstop,
  .battery_backup, .alwayson_standby, .system_mode, .core_supply_request_o,
  .core_supply_request_oe_n, .cluster_supply_request_o, .cluster_supply_request_oe_n,
  .core_regulator_lowpower_n_o, .core_regulator_lowpower_n_oe_n);
`default_nettype wire

// ### verification/regulator_request_pin_logic_test.sv
`timescale 1ns/1ps
`default_nettype none
`include "regulator_request_consts.vh"
module regulator_request_pin_logic_test;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err_q;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd_q;
  logic [3:0]  pstrb;
  logic [5:0]  in_q, e;
  logic [2:0]  system_mode, lvl;
  logic        enhanced_cpu_sleep, alwayson_standby, core_o, core_oe_n, cpu_o, cpu_oe_n;
  logic        lp_o, lp_oe_n;
  int          n_fail, tests_run;
  regulator_request_pin_logic dut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
    .pwdata, .pstrb, .prdata, .pready, .pslverr, .cluster_cstop(in_q[5]),
    .cluster_stop2_wanted(in_q[4]), .system_cstop(in_q[3]), .alwayson_cstop(in_q[2]),
    .cluster_wfi(in_q[1]), .battery_backup(in_q[0]), .enhanced_cpu_sleep,
    .alwayson_standby, .system_mode, .core_supply_request_o(core_o),
    .core_supply_request_oe_n(core_oe_n), .cluster_supply_request_o(cpu_o),
    .cluster_supply_request_oe_n(cpu_oe_n), .core_regulator_lowpower_n_o(lp_o),
    .core_regulator_lowpower_n_oe_n(lp_oe_n));
  regulator_model far (.core_o, .core_oe_n, .cpu_o, .cpu_oe_n, .lp_o, .lp_oe_n, .lvl);
  // ------
  // shared tasks
  // ------
  task automatic complete_run();
    $display("checks %0d failures %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      n_fail++;
      $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  // one apb transfer; the request holds until pready is seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    int n;
    psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d; pstrb <= 4'hf;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge pclk);
      n++;
    end while (pready !== 1'b1 && n < 16);
    if (pready !== 1'b1) begin
      n_fail++;
      complete_run();
    end
    rd_q = prdata; err_q = pslverr; psel <= 1'b0; penable <= 1'b0;
    @(posedge pclk);
  endtask
  // inputs pass a two-flop synchroniser and an output flop, so allow six edges
  task automatic set_in(input logic [5:0] v);
    in_q <= v;
    repeat (6) @(posedge pclk);
  endtask
  // ------
  // scenarios
  // ------
  task automatic do_reset();
    presetn <= 1'b0;
    repeat (10) @(posedge pclk);
    chk({core_o, cpu_o, lp_o, core_oe_n, cpu_oe_n, lp_oe_n}, 6'h0);
    presetn <= 1'b1;
    @(posedge pclk);
    for (int i = 0; i < 16; i += 4) begin
      apb(1'b0, i[11:0], 32'h0);
      chk(rd_q, 32'h0);
    end
    apb(1'b0, 12'h020, 32'h0);
    chk(err_q, 1'b1);
    chk(rd_q, 32'h0000_0000);
  endtask
  task automatic run_modes();
    logic [31:0] c0 [10] = '{0, 0, 32'h1_0000, 32'h3_0000, 32'h3, 32'h3_0000, 32'h1_0000,
                             32'h1_0003, 0, 32'h1_0001};
    logic [31:0] c1 [10] = '{0, 0, 32'h1_0000, 32'h3_0000, 32'h2, 32'h1_0000, 32'h3_0000,
                             32'h1_0002, 0, 32'h1_0002};
    logic [2:0]  md [10] = '{3'h0, 3'h1, 3'h2, 3'h3, 3'h4, 3'h2, 3'h2, 3'h4, 3'h1, 3'h1};
    logic        deep;
    for (int k = 0; k < 3; k++) begin
      apb(1'b1, `RRQ_ADDR_CLUSTER_PIN_CFG, {31'h0, k == 1});
      apb(1'b1, `RRQ_ADDR_SYSTEM_PIN_CFG, {31'h0, k != 0});
      for (int i = 0; i < 10; i++) begin
        apb(1'b1, `RRQ_ADDR_CLUSTER_CPU_CTRL, c0[i]);
        apb(1'b1, `RRQ_ADDR_SYSTEM_CPU_CTRL, c1[i]);
        set_in({i != 0, i == 8, i != 0, 3'h0});
        deep = md[i] > `RRQ_MODE_STOP;
        e = {md[i], !(md[i] == `RRQ_MODE_STANDBY || (k != 0 && deep)),
             !((i != 0 && c0[i][0]) || (k == 1 && i != 0 && (c0[i][16] || i == 8))), !deep};
        chk({system_mode, core_o, cpu_o, lp_o}, e);
        apb(1'b0, `RRQ_ADDR_STATUS, 32'h0);
        chk(rd_q[8:0], {2'h0, md[i], 1'h0, e[0], e[1], e[2]});
      end
    end
  endtask
  task automatic eslp();
    set_in(6'h02);
    chk(enhanced_cpu_sleep, 1'b0);
    apb(1'b1, `RRQ_ADDR_STOP_REQ_SET, 32'h1);
    repeat (4) @(posedge pclk);
    chk(enhanced_cpu_sleep, 1'b1);
    apb(1'b1, `RRQ_ADDR_STOP_REQ_CLR, 32'h1);
    repeat (4) @(posedge pclk);
    chk(enhanced_cpu_sleep, 1'b0);
  endtask
  task automatic aon();
    apb(1'b1, `RRQ_ADDR_CLUSTER_CPU_CTRL, 32'h3);
    apb(1'b1, `RRQ_ADDR_SYSTEM_CPU_CTRL, 32'h2);
    apb(1'b1, `RRQ_ADDR_ALWAYSON_CTRL, 32'h1);
    set_in(6'h2c);
    chk(alwayson_standby, 1'b1);
    apb(1'b1, `RRQ_ADDR_ALWAYSON_CTRL, 32'h0);
    repeat (4) @(posedge pclk);
    chk(alwayson_standby, 1'b0);
    apb(1'b1, `RRQ_ADDR_ALWAYSON_CTRL, 32'h1);
    set_in(6'h24);
    chk(alwayson_standby, 1'b0);
  endtask
  task automatic bat();
    set_in(6'h01);
    chk({core_oe_n, cpu_oe_n, lp_oe_n, lvl}, 6'h38);
    set_in(6'h00);
    chk({core_oe_n, cpu_oe_n, lp_oe_n, lvl}, 6'h07);
  endtask
  // ------
  // clock and main sequence
  // ------
  initial begin
    pclk = 1'b0;
    forever #10 pclk = ~pclk;
  end
  initial begin
    {presetn, psel, penable, pwrite, paddr, pwdata, pstrb, in_q} = '0;
    n_fail = 0;
    tests_run = 0;
    do_reset();
    run_modes();
    eslp();
    aon();
    bat();
    do_reset();
    complete_run();
  end
endmodule
`default_nettype wire
